/* File: scl_regs.vh */
`ifndef SCL_REGS_VH
`define SCL_REGS_VH

// ==========================================================================
// Timing figures, as printed, and cycle counts for four of them at the 125 MHz clock.
// ==========================================================================
`define SCL_CLK_PERIOD_NS     8
`define SCL_POR_LOW_MS        100
`define SCL_CF2CD_MAX_NS      800
`define SCL_CF2ST0_MAX_NS     800
`define SCL_STATUS_MIN_US     10
`define SCL_STATUS_MAX_US     40
`define SCL_CD2UM_MIN_US      6
`define SCL_CD2UM_MAX_US      20
`define SCL_USR_INIT_PERIODS  140
`define SCL_POR_CYCLES        ((`SCL_POR_LOW_MS * 1000000) / `SCL_CLK_PERIOD_NS)
`define SCL_CF2CD_CYCLES      (`SCL_CF2CD_MAX_NS / `SCL_CLK_PERIOD_NS)
`define SCL_STATUS_MIN_CYCLES ((`SCL_STATUS_MIN_US * 1000 + `SCL_CLK_PERIOD_NS - 1) / `SCL_CLK_PERIOD_NS)
`define SCL_CD2UM_MIN_CYCLES  ((`SCL_CD2UM_MIN_US * 1000 + `SCL_CLK_PERIOD_NS - 1) / `SCL_CLK_PERIOD_NS)

// ==========================================================================
// Load scheme selection and TAP instruction codes.
// ==========================================================================
`define SCL_SCHEME_PASSIVE    1'b0
`define SCL_SCHEME_ACTIVE     1'b1
`define SCL_IR_WIDTH          10
`define SCL_IR_PROGRAM        10'h002
`define SCL_IR_BYPASS         10'h3FF

`endif

/* File: scl_sync.v */
`timescale 1ns/1ps
// ==========================================================================
// Two-flop synchroniser for a bank of pin inputs.
// ==========================================================================
module scl_sync #(
	parameter WIDTH = 1,
	parameter RESET_VAL = 0
) (
	// Clock and reset
	input  wire             ref_clk,
	input  wire             reset,
	// Data
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			meta_q <= RESET_VAL[WIDTH-1:0];
			sync_q <= RESET_VAL[WIDTH-1:0];
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule // scl_sync

/* File: scl_tap.v */
`timescale 1ns/1ps
`include "scl_regs.vh"
// ==========================================================================
// Boundary-scan port on the sampled TCK edges.
// ==========================================================================
module scl_tap (
	// Clock and reset
	input  wire ref_clk,
	input  wire reset,
	// Sampled TCK edges and pins
	input  wire tck_rise,
	input  wire tck_fall,
	input  wire tms,
	input  wire tdi,
	// Test data out pin
	output wire tdo_o,
	output wire tdo_oe,
	// Load data path
	output reg  program_active,
	output wire prog_bit_valid,
	output wire prog_bit
);
	localparam ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SDR_SEL = 16'h0004, ST_CAP_DR = 16'h0008;
	localparam ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020, ST_PA_DR = 16'h0040, ST_EX2_DR = 16'h0080;
	localparam ST_UP_DR = 16'h0100, ST_SIR_SEL = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800;
	localparam ST_EX1_IR = 16'h1000, ST_PA_IR = 16'h2000, ST_EX2_IR = 16'h4000, ST_UP_IR = 16'h8000;

	reg [15:0]                  state_q, state_d;
	reg [`SCL_IR_WIDTH-1:0]     ir_shift_q, ir_q;
	reg                         bypass_q;
	reg                         tdo_q, tdo_oe_q;
	wire                        shift_ir = (state_q == ST_SH_IR);
	wire                        shift_dr = (state_q == ST_SH_DR);

	always @* begin
		case (state_q)
		ST_RESET:   state_d = tms ? ST_RESET   : ST_IDLE;
		ST_IDLE:    state_d = tms ? ST_SDR_SEL : ST_IDLE;
		ST_SDR_SEL: state_d = tms ? ST_SIR_SEL : ST_CAP_DR;
		ST_CAP_DR:  state_d = tms ? ST_EX1_DR  : ST_SH_DR;
		ST_SH_DR:   state_d = tms ? ST_EX1_DR  : ST_SH_DR;
		ST_EX1_DR:  state_d = tms ? ST_UP_DR   : ST_PA_DR;
		ST_PA_DR:   state_d = tms ? ST_EX2_DR  : ST_PA_DR;
		ST_EX2_DR:  state_d = tms ? ST_UP_DR   : ST_SH_DR;
		ST_UP_DR:   state_d = tms ? ST_SDR_SEL : ST_IDLE;
		ST_SIR_SEL: state_d = tms ? ST_RESET   : ST_CAP_IR;
		ST_CAP_IR:  state_d = tms ? ST_EX1_IR  : ST_SH_IR;
		ST_SH_IR:   state_d = tms ? ST_EX1_IR  : ST_SH_IR;
		ST_EX1_IR:  state_d = tms ? ST_UP_IR   : ST_PA_IR;
		ST_PA_IR:   state_d = tms ? ST_EX2_IR  : ST_PA_IR;
		ST_EX2_IR:  state_d = tms ? ST_UP_IR   : ST_SH_IR;
		ST_UP_IR:   state_d = tms ? ST_SDR_SEL : ST_IDLE;
		default:    state_d = ST_RESET;
		endcase
	end

	// No TRST pin: five TCK edges with TMS high reach reset.
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_q        <= ST_RESET;
			ir_shift_q     <= `SCL_IR_BYPASS;
			ir_q           <= `SCL_IR_BYPASS;
			bypass_q       <= 1'b0;
			program_active <= 1'b0;
		end else if (tck_rise) begin
			state_q <= state_d;
			if (state_q == ST_CAP_IR)
				ir_shift_q <= {{(`SCL_IR_WIDTH-2){1'b0}}, 2'b01};
			else if (shift_ir)
				ir_shift_q <= {tdi, ir_shift_q[`SCL_IR_WIDTH-1:1]};
			if (shift_dr)
				bypass_q <= tdi;
			if (state_q == ST_RESET) begin
				ir_q           <= `SCL_IR_BYPASS;
				program_active <= 1'b0;
			end else if (state_q == ST_UP_IR) begin
				ir_q           <= ir_shift_q;
				program_active <= (ir_shift_q == `SCL_IR_PROGRAM);
			end
		end
	end

	// TDO changes on falling TCK and floats outside the shift states.
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			tdo_q    <= 1'b0;
			tdo_oe_q <= 1'b0;
		end else if (tck_fall) begin
			tdo_oe_q <= shift_ir | shift_dr;
			tdo_q    <= shift_ir ? ir_shift_q[0] : bypass_q;
		end
	end

	assign tdo_o          = tdo_q;
	assign tdo_oe         = tdo_oe_q;
	assign prog_bit_valid = tck_rise & shift_dr & program_active;
	assign prog_bit       = tdi;
endmodule // scl_tap

/* File: scl_loader.v */
`timescale 1ns/1ps
`include "scl_regs.vh"
// ==========================================================================
// Serial configuration loader: passive serial, active serial, boundary scan.
// ==========================================================================
module scl_loader #(
	parameter        POR_CYCLES  = `SCL_POR_CYCLES,
	parameter [31:0] IMAGE_BITS  = 32'h0000_0100,
	parameter        USE_USR_CLK = 0,
	parameter [15:0] AS_DIV      = 16'h0004
) (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        reset,
	// Scheme strap
	input  wire        scheme_sel,
	// Load request and status, open drain
	input  wire        load_request_n,
	input  wire        status_n_i,
	output wire        status_n_o,
	output wire        status_n_oe,
	// Load complete, open drain
	input  wire        load_done_i,
	output wire        load_done_o,
	output wire        load_done_oe,
	// Serial load clock and data
	input  wire        serial_load_clock_i,
	output wire        serial_load_clock_o,
	output wire        serial_load_clock_oe,
	input  wire        serial_data,
	// Optional initialization clock
	input  wire        user_supplied_init_clock,
	// Boundary-scan pins
	input  wire        tck,
	input  wire        tms,
	input  wire        tdi,
	output wire        tdo_o,
	output wire        tdo_oe,
	// Core side
	output reg         cfg_bit_valid,
	output reg         cfg_bit,
	output reg         cfg_decompress,
	input  wire        cfg_error,
	output wire        user_io_oe_allow,
	output wire        user_mode
);
	// ======================================================================
	// States.
	// ======================================================================
	localparam ST_POR   = 6'h01;
	localparam ST_RST   = 6'h02;
	localparam ST_WAIT  = 6'h04;
	localparam ST_LOAD  = 6'h08;
	localparam ST_INIT  = 6'h10;
	localparam ST_USER  = 6'h20;
	localparam [15:0] STATUS_MIN = `SCL_STATUS_MIN_CYCLES;
	localparam [15:0] CD2UM_MIN  = `SCL_CD2UM_MIN_CYCLES;
	localparam [15:0] USR_INIT   = `SCL_USR_INIT_PERIODS;

	// ======================================================================
	// Pin synchronisers.
	// ======================================================================
	// Serial data shares the clock's two-flop delay, so it still lines up with the found edge.
	wire [7:0] pins_s;
	scl_sync #(.WIDTH(8), .RESET_VAL(8'h03)) u_sync (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.async_in ({serial_data, user_supplied_init_clock, tdi, tms, tck,
		            serial_load_clock_i, status_n_i, load_request_n}),
		.sync_out (pins_s)
	);
	wire req_n_s  = pins_s[0];
	wire stat_n_s = pins_s[1];
	wire sclk_s   = pins_s[2];
	wire tck_s    = pins_s[3];
	wire tms_s    = pins_s[4];
	wire tdi_s    = pins_s[5];
	wire usr_s    = pins_s[6];
	wire data_s   = pins_s[7];

	reg  sclk_prev_q, tck_prev_q, usr_prev_q, scheme_q;
	wire sclk_rise = sclk_s & ~sclk_prev_q;
	wire tck_rise  = tck_s & ~tck_prev_q;
	wire tck_fall  = ~tck_s & tck_prev_q;
	wire usr_rise  = usr_s & ~usr_prev_q;

	// ======================================================================
	// Boundary-scan port.
	// ======================================================================
	wire jtag_prog, jtag_bit_v, jtag_bit;
	scl_tap u_tap (
		.ref_clk        (ref_clk),
		.reset          (reset),
		.tck_rise       (tck_rise),
		.tck_fall       (tck_fall),
		.tms            (tms_s),
		.tdi            (tdi_s),
		.tdo_o          (tdo_o),
		.tdo_oe         (tdo_oe),
		.program_active (jtag_prog),
		.prog_bit_valid (jtag_bit_v),
		.prog_bit       (jtag_bit)
	);

	// ======================================================================
	// Main sequencer.
	// ======================================================================
	reg  [5:0]  state_q;
	reg  [31:0] por_cnt_q;
	reg  [15:0] tmr_q;
	reg  [31:0] bit_cnt_q;
	reg         jtag_load_q;
	reg         err_q;
	reg  [15:0] div_q;
	reg         as_clk_q;
	wire        as_mode   = (scheme_q == `SCL_SCHEME_ACTIVE);
	wire        as_rise   = as_mode && (div_q == AS_DIV) && !as_clk_q;
	wire        take_bit  = jtag_load_q ? jtag_bit_v : (as_mode ? as_rise : sclk_rise);
	wire        take_val  = jtag_load_q ? jtag_bit : data_s;
	wire        jtag_start = jtag_prog && !jtag_load_q;

	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_q        <= ST_POR;
			por_cnt_q      <= 32'h0000_0000;
			tmr_q          <= 16'h0000;
			bit_cnt_q      <= 32'h0000_0000;
			jtag_load_q    <= 1'b0;
			err_q          <= 1'b0;
			sclk_prev_q    <= 1'b0;
			tck_prev_q     <= 1'b0;
			usr_prev_q     <= 1'b0;
			scheme_q       <= `SCL_SCHEME_PASSIVE;
			div_q          <= 16'h0000;
			as_clk_q       <= 1'b0;
			cfg_bit_valid  <= 1'b0;
			cfg_bit        <= 1'b0;
			cfg_decompress <= 1'b0;
		end else begin
			sclk_prev_q   <= sclk_s;
			tck_prev_q    <= tck_s;
			usr_prev_q    <= usr_s;
			cfg_bit_valid <= 1'b0;
			if (state_q == ST_POR || state_q == ST_RST)
				scheme_q <= scheme_sel;
			if (as_mode && state_q == ST_LOAD && !jtag_load_q) begin
				div_q <= (div_q == AS_DIV) ? 16'h0000 : div_q + 16'h0001;
				if (div_q == AS_DIV)
					as_clk_q <= ~as_clk_q;
			end else begin
				div_q    <= 16'h0000;
				as_clk_q <= 1'b0;
			end
			if (jtag_start) begin
				state_q     <= ST_LOAD;
				jtag_load_q <= 1'b1;
				bit_cnt_q   <= 32'h0000_0000;
				err_q       <= 1'b0;
			end else if (!req_n_s && state_q != ST_POR && !jtag_load_q) begin
				state_q <= ST_RST;
				tmr_q   <= 16'h0000;
				err_q   <= 1'b0;
			end else begin
				case (state_q)
				ST_POR: begin
					por_cnt_q <= por_cnt_q + 32'h0000_0001;
					if (por_cnt_q >= POR_CYCLES - 1)
						state_q <= ST_WAIT;
				end
				ST_RST: begin
					if (tmr_q < STATUS_MIN)
						tmr_q <= tmr_q + 16'h0001;
					else if (req_n_s)
						state_q <= ST_WAIT;
				end
				ST_WAIT: begin
					bit_cnt_q <= 32'h0000_0000;
					if (stat_n_s && !err_q)
						state_q <= ST_LOAD;
				end
				ST_LOAD: begin
					if (cfg_error && !jtag_load_q)
						err_q <= 1'b1;
					else if (!err_q && take_bit) begin
						cfg_bit_valid  <= 1'b1;
						cfg_bit        <= take_val;
						cfg_decompress <= !jtag_load_q;
						bit_cnt_q      <= bit_cnt_q + 32'h0000_0001;
						if (bit_cnt_q == IMAGE_BITS - 1) begin
							state_q <= ST_INIT;
							tmr_q   <= 16'h0000;
						end
					end
				end
				ST_INIT: begin
					if (USE_USR_CLK != 0) begin
						if (usr_rise)
							tmr_q <= tmr_q + 16'h0001;
						if (tmr_q >= USR_INIT)
							state_q <= ST_USER;
					end else begin
						tmr_q <= tmr_q + 16'h0001;
						if (tmr_q >= CD2UM_MIN)
							state_q <= ST_USER;
					end
				end
				ST_USER: begin
					jtag_load_q <= 1'b0;
				end
				default: state_q <= ST_POR;
				endcase
			end
		end
	end

	// ======================================================================
	// Pin drive. Open-drain lines only ever pull low.
	// ======================================================================
	// An error holds status low until the host pulses the request line or a scan load starts.
	assign status_n_o   = 1'b0;
	assign status_n_oe  = (state_q == ST_POR) || (state_q == ST_RST) || err_q;
	assign load_done_o  = 1'b0;
	assign load_done_oe = (state_q == ST_POR) || (state_q == ST_RST) ||
	                      (state_q == ST_WAIT) || (state_q == ST_LOAD);
	assign serial_load_clock_o  = as_clk_q;
	assign serial_load_clock_oe = as_mode && (state_q != ST_POR);
	assign user_io_oe_allow     = (state_q == ST_USER) && !jtag_prog && !jtag_load_q;
	assign user_mode            = (state_q == ST_USER);
endmodule // scl_loader

/* File: scl_monitor.sv */
`timescale 1ns/1ps
`include "scl_regs.vh"
// ====================
// Pin checker for the loader.
module scl_monitor #(
	parameter POR_CYCLES = 50,
	parameter IMAGE_BITS = 16
) (
	// Clock and reset
	input wire ref_clk,
	input wire reset,
	// Load port
	input wire scheme_sel,
	input wire load_request_n,
	input wire status_n_oe,
	input wire load_done_oe,
	input wire serial_load_clock_oe,
	// Scan and core side
	input wire tck,
	input wire tdo_o,
	input wire cfg_bit_valid,
	input wire cfg_decompress,
	input wire cfg_error,
	input wire user_mode
);
	localparam int HOLD_MAX = 5000;
	reg [15:0] low_q;
	reg [15:0] hold_q;
	reg [15:0] bits_q;
	reg [15:0] init_q;
	reg        req_q;
	reg        arm_q;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// ====================
	// Helper counters.
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			low_q  <= 16'h0000;
			hold_q <= 16'h0000;
			bits_q <= 16'h0000;
			init_q <= 16'h0000;
			req_q  <= 1'b0;
			arm_q  <= 1'b0;
		end else begin
			low_q  <= status_n_oe ? low_q + 16'h0001 : 16'h0000;
			hold_q <= (arm_q && load_request_n) ? hold_q + 16'h0001 : 16'h0000;
			bits_q <= status_n_oe ? 16'h0000 : bits_q + {15'h0000, cfg_bit_valid};
			init_q <= load_done_oe ? 16'h0000 : init_q + {15'h0000, !user_mode};
			req_q  <= req_q | !load_request_n;
			// Only a request arms the release timer, so an error hold is not mistaken for a slow release.
			arm_q  <= !load_request_n | (arm_q & status_n_oe);
		end
	end
	// ====================
	// Assertions.
	property p_req_status; $fell(load_request_n) |-> ##[1:100] status_n_oe; endproperty
	a_req_status: assert property (p_req_status) else $error("status not pulled low");
	property p_req_done; $fell(load_request_n) |-> ##[1:100] load_done_oe; endproperty
	a_req_done: assert property (p_req_done) else $error("complete not pulled low");
	property p_por_low; $fell(status_n_oe) && !req_q |-> low_q >= POR_CYCLES - 1; endproperty
	a_por_low: assert property (p_por_low) else $error("power-up hold too short");
	property p_release; hold_q < HOLD_MAX; endproperty
	a_release: assert property (p_release) else $error("status release late");
	// The last bit's pulse stands in the cycle the line is released, so it is added here.
	property p_done_bits; $fell(load_done_oe) |-> bits_q + {15'h0000, cfg_bit_valid} == IMAGE_BITS; endproperty
	a_done_bits: assert property (p_done_bits) else $error("complete at wrong bit count");
	property p_init; $rose(user_mode) |-> init_q >= 750 && init_q <= 2500; endproperty
	a_init: assert property (p_init) else $error("user mode delay wrong");
	property p_err; cfg_error && load_done_oe && !status_n_oe |-> ##[1:8] status_n_oe; endproperty
	a_err: assert property (p_err) else $error("error not flagged");
	// The pin passes two sync flops, so a falling-edge update lands three or more cycles late.
	property p_tdo_edge; $changed(tdo_o) |-> !$past(tck, 3); endproperty
	a_tdo_edge: assert property (p_tdo_edge) else $error("tdo moved off falling edge");
	property p_as_clk; serial_load_clock_oe |-> scheme_sel == `SCL_SCHEME_ACTIVE; endproperty
	a_as_clk: assert property (p_as_clk) else $error("load clock driven in passive scheme");
	c_user: cover property ($rose(user_mode));
	c_err: cover property (cfg_error && load_done_oe);
	c_scan: cover property (cfg_bit_valid && !cfg_decompress);
endmodule // scl_monitor

bind scl_loader scl_monitor #(.POR_CYCLES(POR_CYCLES), .IMAGE_BITS(IMAGE_BITS)) u_monitor (
	.ref_clk(ref_clk), .reset(reset), .scheme_sel(scheme_sel), .load_request_n(load_request_n),
	.status_n_oe(status_n_oe), .load_done_oe(load_done_oe), .serial_load_clock_oe(serial_load_clock_oe),
	.tck(tck), .tdo_o(tdo_o), .cfg_bit_valid(cfg_bit_valid), .cfg_decompress(cfg_decompress),
	.cfg_error(cfg_error), .user_mode(user_mode)
);

/* File: scl_host_model.sv */
`timescale 1ns/1ps
// ====================
// Host that pulses the request and clocks bytes in.
module scl_host_model (
	// Clock
	input  wire  ref_clk,
	// Load port
	output logic load_request_n,
	output logic serial_load_clock,
	output logic serial_data
);
	// A 128 ns load clock, the nearest whole number of reference cycles to 125 ns.
	localparam int HALF = 8;
	initial begin
		load_request_n    = 1'b1;
		serial_load_clock = 1'b0;
		serial_data       = 1'b1;
	end
	task automatic request(input int low_cycles);
		@(posedge ref_clk) load_request_n <= 1'b0;
		repeat (low_cycles) @(posedge ref_clk);
		load_request_n <= 1'b1;
	endtask
	// Data keeps its last bit after a byte and the clock rests low.
	task automatic send_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk) serial_data <= b[i];
			repeat (HALF - 1) @(posedge ref_clk);
			serial_load_clock <= 1'b1;
			repeat (HALF) @(posedge ref_clk);
			serial_load_clock <= 1'b0;
		end
	endtask
endmodule // scl_host_model

/* File: serial_config_loader_bench.sv */
`timescale 1ns/1ps
`include "scl_regs.vh"
// ====================
// Bench for the serial configuration loader.
module serial_config_loader_bench;
	localparam int POR  = 50;
	localparam int BITS = 16;
	logic       ref_clk     = 1'b0;
	logic       reset       = 1'b1;
	logic       scheme_sel  = `SCL_SCHEME_PASSIVE;
	logic       cfg_error   = 1'b0;
	logic       tck         = 1'b0;
	logic       tms         = 1'b1;
	logic       tdi         = 1'b1;
	logic [1:0] usr_div     = 2'h0;
	logic [1:0] got[$];
	int         mismatches  = 0;
	int         checks_done = 0;
	wire        load_request_n, host_clk, host_data, status_n_oe, load_done_oe, clk_o, clk_oe;
	wire        status_pull, done_pull;
	wire        tdo_o, tdo_oe, bit_valid, cfg_bit, cfg_decompress, io_allow, user_mode;
	// Open-drain lines have pull-ups; the load clock comes from whichever side drives it.
	wire        status_line = status_n_oe ? status_pull : 1'b1;
	wire        done_line   = load_done_oe ? done_pull : 1'b1;
	wire        load_clk    = clk_oe ? clk_o : host_clk;
	initial forever #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) usr_div <= usr_div + 2'h1;
	scl_loader #(.POR_CYCLES(POR), .IMAGE_BITS(BITS)) u_dut (
		.ref_clk(ref_clk), .reset(reset), .scheme_sel(scheme_sel), .load_request_n(load_request_n),
		.status_n_i(status_line), .status_n_o(status_pull), .status_n_oe(status_n_oe),
		.load_done_i(done_line), .load_done_o(done_pull), .load_done_oe(load_done_oe),
		.serial_load_clock_i(load_clk), .serial_load_clock_o(clk_o), .serial_load_clock_oe(clk_oe),
		.serial_data(host_data), .user_supplied_init_clock(usr_div[1]), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo_o(tdo_o), .tdo_oe(tdo_oe), .cfg_bit_valid(bit_valid), .cfg_bit(cfg_bit),
		.cfg_decompress(cfg_decompress), .cfg_error(cfg_error), .user_io_oe_allow(io_allow), .user_mode(user_mode)
	);
	scl_host_model u_host (
		.ref_clk(ref_clk), .load_request_n(load_request_n), .serial_load_clock(host_clk), .serial_data(host_data)
	);
	always @(posedge ref_clk) begin
		if (bit_valid === 1'b1) begin
			got.push_back({cfg_decompress, cfg_bit});
		end
	end
	// ====================
	// Compare, wait and close.
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic g, input logic e, input string m);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask
	task automatic chk_in(input int v, input int lo, input int hi, input string m);
		chk(v >= lo && v <= hi, 1'b1, m);
	endtask
	task automatic wait_for(input int sel, input logic lvl, input int lim, output int n);
		logic s;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
			s = (sel == 0) ? status_line : (sel == 1) ? done_line : user_mode;
		end while (s !== lvl && n < lim);
		if (s !== lvl) begin
			mismatches++;
			$display("ERROR %0t wait timed out", $time);
			complete_run();
		end
	endtask
	task automatic tck_bit(input logic m, input logic d);
		@(posedge ref_clk);
		tms <= m;
		tdi <= d;
		repeat (8) @(posedge ref_clk);
		tck <= 1'b1;
		repeat (8) @(posedge ref_clk);
		tck <= 1'b0;
		#1;
	endtask
	// ====================
	// Scenarios.
	task automatic t_por();
		int n;
		chk(status_line, 1'b0, "status high at power-up");
		wait_for(0, 1'b1, 200, n);
		chk_in(n, POR - 2, POR + 10, "power-up hold");
		chk(done_line, 1'b0, "complete before load");
		chk(tdo_oe, 1'b0, "tdo driven idle");
		chk(clk_oe, 1'b0, "load clock driven");
	endtask
	task automatic t_start();
		int n;
		got.delete();
		fork
			u_host.request(5000);
			wait_for(0, 1'b0, 100, n);
		join
		chk(done_line, 1'b0, "complete not cleared");
		wait_for(0, 1'b1, 6000, n);
		chk_in(n, `SCL_STATUS_MIN_CYCLES, 5000, "status release time");
		repeat (5000) @(posedge ref_clk);
	endtask
	task automatic t_load(input logic [15:0] img);
		int n;
		t_start();
		u_host.send_byte(img[7:0]);
		chk(done_line, 1'b0, "complete early");
		u_host.send_byte(img[15:8]);
		wait_for(1, 1'b1, 20, n);
		chk(got.size() == BITS, 1'b1, "bit count");
		for (int i = 0; i < BITS; i++) begin
			chk(got[i][0], img[i], "bit order");
		end
		wait_for(2, 1'b1, 3000, n);
		chk_in(n, 740, 2500, "user mode delay");
		chk(io_allow, 1'b1, "pins held in user mode");
	endtask
	task automatic t_error();
		int n;
		t_start();
		u_host.send_byte(8'h5A);
		@(posedge ref_clk) cfg_error <= 1'b1;
		@(posedge ref_clk) cfg_error <= 1'b0;
		wait_for(0, 1'b0, 8, n);
		u_host.send_byte(8'hFF);
		chk(got.size() == 8, 1'b1, "bits taken after error");
		chk(done_line, 1'b0, "complete after error");
	endtask
	task automatic t_jtag();
		logic [9:0] ir;
		logic [7:0] dat;
		ir = `SCL_IR_PROGRAM;
		dat = 8'hC6;
		t_start();
		u_host.send_byte(8'h0F);
		got.delete();
		for (int i = 0; i < 10; i++) begin
			tck_bit(i < 5 || i == 6 || i == 7, 1'b1);
		end
		for (int i = 0; i < 10; i++) begin
			tck_bit(i == 9, ir[i]);
			if (i == 0)
				chk(tdo_o, 1'b1, "capture pattern not shifted out");
		end
		for (int i = 0; i < 4; i++) begin
			tck_bit(i < 2, 1'b1);
		end
		u_host.send_byte(8'hFF);
		chk(got.size() == 0, 1'b1, "serial bits after scan entry");
		for (int i = 0; i < 8; i++) begin
			tck_bit(i == 7, dat[i]);
			if (i == 3) begin
				chk(tdo_oe, 1'b1, "tdo off while shifting");
				chk(io_allow, 1'b0, "pins driven in scan load");
			end
		end
		tck_bit(1'b1, 1'b1);
		tck_bit(1'b0, 1'b1);
		chk(tdo_oe, 1'b0, "tdo driven idle");
		chk(got.size() == 8, 1'b1, "scan bit count");
		for (int i = 0; i < 8; i++) begin
			chk(got[i] === {1'b0, dat[i]}, 1'b1, "scan bit value");
		end
	endtask
	task automatic t_active();
		int   n;
		logic prev;
		@(posedge ref_clk);
		scheme_sel <= `SCL_SCHEME_ACTIVE;
		reset <= 1'b1;
		repeat (12) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (POR + 20) @(posedge ref_clk);
		#1;
		chk(clk_oe, 1'b1, "load clock not driven");
		n = 0;
		prev = clk_o;
		repeat (40) begin
			@(posedge ref_clk);
			#1;
			n += (clk_o !== prev);
			prev = clk_o;
		end
		chk_in(n, 7, 9, "load clock rate");
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		reset <= 1'b0;
		t_por();
		t_load(16'h3CA5);
		t_error();
		t_load(16'hC35A);
		t_jtag();
		t_active();
		complete_run();
	end
endmodule // serial_config_loader_bench
